/* File: verilog/general_timer_module.v */
`timescale 1ns/1ps
`include "gp_timer_defines.vh"
module general_timer_module #(
  parameter RTC_DIVIDE = `RTC_IN_HZ / `RTC_OUT_HZ
) (
  input  wire        clk_in,
  input  wire        sys_rst_in,
  input  wire [7:0]  avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [31:0] avs_writedata_in,
  input  wire [3:0]  avs_byteenable_in,
  output reg  [31:0] avs_readdata_out,
  output reg         avs_waitrequest_out,
  input  wire        cpu_halted_in,
  input  wire        capture_compare_pin_in,
  output reg         adc_trigger_out,
  output reg         irq_out
);

  reg  [2:0]  width_config_selector;
  reg  [1:0]  counter_a_mode_field;
  reg  [1:0]  counter_b_mode_field;
  reg  [15:0] timer_control_reg;
  reg  [15:0] irq_mask_reg;
  reg  [15:0] raw_irq_status;
  reg  [15:0] counter_a_interval_load;
  reg  [15:0] counter_b_interval_load;
  reg  [15:0] count_a;
  reg  [15:0] count_b;
  reg  [7:0]  counter_a_prescale;
  reg  [7:0]  counter_b_prescale;
  reg  [7:0]  prescale_count_a;
  reg  [7:0]  prescale_count_b;
  reg  [31:0] counter_a_match;

  reg  [31:0] next_count;
  reg  [7:0]  next_prescale_a;
  reg  [7:0]  next_prescale_b;
  reg  [15:0] next_control;
  reg  [2:0]  next_event;
  reg  [24:0] next_step_a;
  reg  [24:0] next_step_b;
  reg  [31:0] next_readdata;

  wire [31:0] count32;
  wire        wide_mode;
  wire        freeze_a;
  wire        freeze_b;
  wire        clock_freeze;
  wire        clock_run;
  wire        clock_tick;
  wire        bus_write;
  wire [31:0] write_value;
  wire [15:0] clear_bits;
  wire [15:0] event_bits;
  wire [15:0] masked_irq_status;

  // A literal cannot be part-selected, so the clock preset is named at full width first
  localparam [31:0] CLOCK_PRESET = `RTC_PRESET;

  function [31:0] merge_bytes;
    input [31:0] old_word;
    input [31:0] new_word;
    input [3:0]  lanes;
    integer k;
    begin
      merge_bytes = old_word;
      for (k = 0; k < 4; k = k + 1) begin
        if (lanes[k]) begin
          merge_bytes[8*k +: 8] = new_word[8*k +: 8];
        end
      end
    end
  endfunction

  // Result is {timeout, count, prescale}
  function [24:0] step16;
    input [15:0] cnt;
    input [7:0]  pre_cnt;
    input [15:0] load;
    input [7:0]  pre_load;
    begin
      if (pre_cnt != 8'h00) begin
        step16 = {1'b0, cnt, pre_cnt - 8'h01};
      end else if (cnt == `ZERO16) begin
        step16 = {1'b1, load, pre_load};
      end else begin
        step16 = {1'b0, cnt - 16'h0001, pre_load};
      end
    end
  endfunction

  function counting_mode;
    input [1:0] mode;
    begin
      counting_mode = (mode == `MODE_ONESHOT) || (mode == `MODE_PERIODIC);
    end
  endfunction

  assign count32   = {count_b, count_a};
  assign wide_mode = (width_config_selector == `CFG_32) || (width_config_selector == `CFG_RTC);
  assign freeze_a  = timer_control_reg[`CTL_ASTALL] & cpu_halted_in;
  assign freeze_b  = timer_control_reg[`CTL_BSTALL] & cpu_halted_in;
  // Clock mode keeps time through a debug halt when its enable is set
  assign clock_freeze = (timer_control_reg[`CTL_ASTALL] | timer_control_reg[`CTL_BSTALL])
                        & cpu_halted_in & ~timer_control_reg[`CTL_CLOCK_CALENDAR_ENABLE];
  assign clock_run = (width_config_selector == `CFG_RTC) & timer_control_reg[`CTL_AEN] & ~clock_freeze;

  assign bus_write   = avs_write_in & ~avs_waitrequest_out;
  // Readback of the addressed word doubles as the base for byte-lane merging
  assign write_value = merge_bytes(next_readdata, avs_writedata_in, avs_byteenable_in);
  assign clear_bits  = (bus_write && (avs_address_in == `OFS_ICLR)) ?
                       (write_value[15:0] & `IRQ_MASK) : `ZERO16;
  assign event_bits  = ({15'h0000, next_event[0]} << `IRQ_ATO) |
                       ({15'h0000, next_event[1]} << `IRQ_BTO) |
                       ({15'h0000, next_event[2]} << `IRQ_RTC);
  assign masked_irq_status = raw_irq_status & irq_mask_reg;

  rtc_divider #(
    .DIVIDE (RTC_DIVIDE),
    .CW     (16)
  ) u_rtc_divider (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .run_in     (clock_run),
    .pin_in     (capture_compare_pin_in),
    .tick_out   (clock_tick)
  );

  // Counting engine for all three width configurations
  always @* begin
    next_count      = count32;
    next_prescale_a = prescale_count_a;
    next_prescale_b = prescale_count_b;
    next_control    = timer_control_reg;
    next_event      = 3'h0;
    next_step_a     = step16(count_a, prescale_count_a, counter_a_interval_load, counter_a_prescale);
    next_step_b     = step16(count_b, prescale_count_b, counter_b_interval_load, counter_b_prescale);
    if (width_config_selector == `CFG_32) begin
      if (timer_control_reg[`CTL_AEN] && counting_mode(counter_a_mode_field) && !freeze_a) begin
        if (count32 == `ZERO32) begin
          next_count    = {counter_b_interval_load, counter_a_interval_load};
          next_event[0] = 1'b1;
          if (counter_a_mode_field == `MODE_ONESHOT) begin
            next_control[`CTL_AEN] = 1'b0;
          end
        end else begin
          next_count = count32 - 32'h00000001;
        end
      end
    end else if (width_config_selector == `CFG_RTC) begin
      if (clock_run && clock_tick) begin
        if (count32 == counter_a_match) begin
          next_count    = `ZERO32;
          next_event[2] = 1'b1;
        end else begin
          next_count = count32 + 32'h00000001;
        end
      end
    end else if (width_config_selector == `CFG_16) begin
      if (timer_control_reg[`CTL_AEN] && counting_mode(counter_a_mode_field) && !freeze_a) begin
        next_count[15:0] = next_step_a[23:8];
        next_prescale_a  = next_step_a[7:0];
        next_event[0]    = next_step_a[24];
        if (next_step_a[24] && (counter_a_mode_field == `MODE_ONESHOT)) begin
          next_control[`CTL_AEN] = 1'b0;
        end
      end
      if (timer_control_reg[`CTL_BEN] && counting_mode(counter_b_mode_field) && !freeze_b) begin
        next_count[31:16] = next_step_b[23:8];
        next_prescale_b   = next_step_b[7:0];
        next_event[1]     = next_step_b[24];
        if (next_step_b[24] && (counter_b_mode_field == `MODE_ONESHOT)) begin
          next_control[`CTL_BEN] = 1'b0;
        end
      end
    end
  end

  // Readback mux; unmapped or misaligned addresses read as zero
  always @* begin
    next_readdata = `ZERO32;
    if (avs_address_in == `OFS_CFG) begin
      next_readdata = {29'h00000000, width_config_selector};
    end else if (avs_address_in == `OFS_AMODE) begin
      next_readdata = {30'h00000000, counter_a_mode_field};
    end else if (avs_address_in == `OFS_BMODE) begin
      next_readdata = {30'h00000000, counter_b_mode_field};
    end else if (avs_address_in == `OFS_CTL) begin
      next_readdata = {16'h0000, timer_control_reg};
    end else if (avs_address_in == `OFS_IMASK) begin
      next_readdata = {16'h0000, irq_mask_reg};
    end else if (avs_address_in == `OFS_RIS) begin
      next_readdata = {16'h0000, raw_irq_status};
    end else if (avs_address_in == `OFS_MIS) begin
      next_readdata = {16'h0000, masked_irq_status};
    end else if (avs_address_in == `OFS_ALOAD) begin
      next_readdata = wide_mode ? {counter_b_interval_load, counter_a_interval_load} :
                                  {16'h0000, counter_a_interval_load};
    end else if (avs_address_in == `OFS_BLOAD) begin
      next_readdata = {16'h0000, counter_b_interval_load};
    end else if (avs_address_in == `OFS_AMATCH) begin
      next_readdata = counter_a_match;
    end else if (avs_address_in == `OFS_APRE) begin
      next_readdata = {24'h000000, counter_a_prescale};
    end else if (avs_address_in == `OFS_BPRE) begin
      next_readdata = {24'h000000, counter_b_prescale};
    end else if (avs_address_in == `OFS_AVAL) begin
      next_readdata = wide_mode ? count32 : {16'h0000, count_a};
    end else if (avs_address_in == `OFS_BVAL) begin
      next_readdata = {16'h0000, count_b};
    end
  end

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      width_config_selector   <= `CFG_32;
      counter_a_mode_field    <= 2'h0;
      counter_b_mode_field    <= 2'h0;
      timer_control_reg       <= `ZERO16;
      irq_mask_reg            <= `ZERO16;
      raw_irq_status          <= `ZERO16;
      counter_a_interval_load <= `RST_LOAD;
      counter_b_interval_load <= `RST_LOAD;
      count_a                 <= `RST_CNT;
      count_b                 <= `RST_CNT;
      counter_a_prescale      <= `RST_PRE;
      counter_b_prescale      <= `RST_PRE;
      prescale_count_a        <= `RST_PRE;
      prescale_count_b        <= `RST_PRE;
      counter_a_match         <= `RST_MATCH;
      avs_readdata_out        <= `ZERO32;
      avs_waitrequest_out     <= 1'b1;
      adc_trigger_out         <= 1'b0;
      irq_out                 <= 1'b0;
    end else begin
      count_a           <= next_count[15:0];
      count_b           <= next_count[31:16];
      prescale_count_a  <= next_prescale_a;
      prescale_count_b  <= next_prescale_b;
      timer_control_reg <= next_control;
      // A new event wins over a clear in the same cycle
      raw_irq_status    <= (raw_irq_status & ~clear_bits) | event_bits;
      adc_trigger_out   <= (next_event[0] & timer_control_reg[`CTL_AOTE]) |
                           (next_event[1] & timer_control_reg[`CTL_BOTE]);
      irq_out           <= |masked_irq_status;

      // One wait cycle per access keeps read data registered
      if (avs_waitrequest_out && (avs_read_in || avs_write_in)) begin
        avs_waitrequest_out <= 1'b0;
        avs_readdata_out    <= next_readdata;
      end else begin
        avs_waitrequest_out <= 1'b1;
      end

      if (bus_write) begin
        if (avs_address_in == `OFS_CFG) begin
          width_config_selector <= write_value[2:0];
          if ((write_value[2:0] == `CFG_RTC) && (width_config_selector != `CFG_RTC)) begin
            count_a <= CLOCK_PRESET[15:0];
            count_b <= CLOCK_PRESET[31:16];
          end
        end else if (avs_address_in == `OFS_AMODE) begin
          counter_a_mode_field <= write_value[1:0];
        end else if (avs_address_in == `OFS_BMODE) begin
          counter_b_mode_field <= write_value[1:0];
        end else if (avs_address_in == `OFS_CTL) begin
          timer_control_reg <= write_value[15:0] & `CTL_MASK;
        end else if (avs_address_in == `OFS_IMASK) begin
          irq_mask_reg <= write_value[15:0] & `IRQ_MASK;
        end else if (avs_address_in == `OFS_ALOAD) begin
          counter_a_interval_load <= write_value[15:0];
          if (wide_mode) begin
            counter_b_interval_load <= write_value[31:16];
          end
          // Clock mode keeps its count; only the down-counting modes preload
          if (width_config_selector == `CFG_32) begin
            count_a <= write_value[15:0];
            count_b <= write_value[31:16];
          end else if (width_config_selector == `CFG_16) begin
            count_a          <= write_value[15:0];
            prescale_count_a <= counter_a_prescale;
          end
        end else if (avs_address_in == `OFS_BLOAD) begin
          counter_b_interval_load <= write_value[15:0];
          if (width_config_selector == `CFG_16) begin
            count_b          <= write_value[15:0];
            prescale_count_b <= counter_b_prescale;
          end
        end else if (avs_address_in == `OFS_AMATCH) begin
          counter_a_match <= write_value;
        end else if (avs_address_in == `OFS_APRE) begin
          counter_a_prescale <= write_value[7:0];
        end else if (avs_address_in == `OFS_BPRE) begin
          counter_b_prescale <= write_value[7:0];
        end
      end
    end
  end

endmodule

/* File: verilog/gp_timer_defines.vh */
`ifndef GP_TIMER_DEFINES_VH
`define GP_TIMER_DEFINES_VH

`define OFS_CFG     8'h00
`define OFS_AMODE   8'h04
`define OFS_BMODE   8'h08
`define OFS_CTL     8'h0C
`define OFS_IMASK   8'h18
`define OFS_RIS     8'h1C
`define OFS_MIS     8'h20
`define OFS_ICLR    8'h24
`define OFS_ALOAD   8'h28
`define OFS_BLOAD   8'h2C
`define OFS_AMATCH  8'h30
`define OFS_APRE    8'h38
`define OFS_BPRE    8'h3C
`define OFS_AVAL    8'h48
`define OFS_BVAL    8'h4C

`define CFG_32      3'h0
`define CFG_RTC     3'h1
`define CFG_16      3'h4

`define MODE_ONESHOT  2'h1
`define MODE_PERIODIC 2'h2

`define CTL_AEN     0
`define CTL_ASTALL  1
`define CTL_CLOCK_CALENDAR_ENABLE   4
`define CTL_AOTE    5
`define CTL_BEN     8
`define CTL_BSTALL  9
`define CTL_BOTE    13
`define CTL_MASK    16'h2333

`define IRQ_ATO     0
`define IRQ_RTC     3
`define IRQ_BTO     8
`define IRQ_MASK    16'h0109

`define RST_CNT     16'hFFFF
`define RST_LOAD    16'hFFFF
`define RST_PRE     8'h00
`define RST_MATCH   32'hFFFFFFFF
`define RTC_PRESET  32'h00000001
`define ZERO16      16'h0000
`define ZERO32      32'h00000000

`define RTC_IN_HZ   32768
`define RTC_OUT_HZ  1

`endif

/* File: verilog/rtc_divider.v */
`timescale 1ns/1ps
module rtc_divider #(
  parameter DIVIDE = 32768,
  parameter CW     = 16
) (
  input  wire clk_in,
  input  wire sys_rst_in,
  input  wire run_in,
  input  wire pin_in,
  output reg  tick_out
);
  localparam integer LAST_I = DIVIDE - 1;
  localparam [CW-1:0] LAST  = LAST_I[CW-1:0];

  reg          pin_prev;
  reg [CW-1:0] edges;

  // Counts rising edges of the slow clock; one tick per DIVIDE edges
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      pin_prev <= 1'b0;
      edges    <= {CW{1'b0}};
      tick_out <= 1'b0;
    end else begin
      pin_prev <= pin_in;
      tick_out <= 1'b0;
      if (!run_in) begin
        edges <= {CW{1'b0}};
      end else if (pin_in && !pin_prev) begin
        if (edges == LAST) begin
          edges    <= {CW{1'b0}};
          tick_out <= 1'b1;
        end else begin
          edges <= edges + {{(CW-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule

/* File: tb/gp_timer_monitor.sv */
`timescale 1ns/1ps
`include "gp_timer_defines.vh"
module gp_timer_monitor (
  input wire        clk_in,
  input wire        sys_rst_in,
  input wire [7:0]  avs_address_in,
  input wire        avs_read_in,
  input wire        avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [31:0] avs_readdata_out,
  input wire        avs_waitrequest_out,
  input wire        cpu_halted_in,
  input wire        adc_trigger_out,
  input wire        irq_out
);
  // Shadows of software-owned bits; hardware only ever clears the enables, never these
  reg [15:0] ctl_sh;
  reg [15:0] msk_sh;
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      ctl_sh <= 16'h0000;
      msk_sh <= 16'h0000;
    end else if (avs_write_in && !avs_waitrequest_out) begin
      if (avs_address_in == `OFS_CTL) ctl_sh <= avs_writedata_in[15:0];
      if (avs_address_in == `OFS_IMASK) msk_sh <= avs_writedata_in[15:0];
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  AST_RST_IDLE: assert property (disable iff (1'b0) sys_rst_in |=>
    avs_waitrequest_out && !adc_trigger_out && !irq_out && avs_readdata_out == 32'h00000000)
    else $error("outputs not idle after reset");
  AST_WAIT_ONE: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("access not answered after one wait cycle");
  AST_WAIT_SHORT: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low for more than one cycle");
  AST_RDATA_HOLD: assert property ($changed(avs_readdata_out) |-> !avs_waitrequest_out)
    else $error("read data changed outside an answer");
  AST_IRQ_FALL: assert property ($fell(irq_out) |-> $past(avs_write_in, 2))
    else $error("interrupt dropped without a software write");
  AST_IRQ_MASK: assert property (irq_out |-> $past(msk_sh) != 16'h0000)
    else $error("interrupt raised with every source masked");
  AST_ADC_GATE: assert property (adc_trigger_out |-> ctl_sh[`CTL_AOTE] || ctl_sh[`CTL_BOTE])
    else $error("adc trigger without trigger enable");
  AST_STALL: assert property ((cpu_halted_in && ctl_sh[`CTL_ASTALL] && ctl_sh[`CTL_BSTALL]
    && !ctl_sh[`CTL_CLOCK_CALENDAR_ENABLE]) [*3] |-> !adc_trigger_out)
    else $error("timer ran while frozen by debug halt");
  COV_ADC: cover property (adc_trigger_out);
  COV_IRQ: cover property ($rose(irq_out));
  COV_HALT: cover property (cpu_halted_in && ctl_sh[`CTL_CLOCK_CALENDAR_ENABLE] && irq_out);
endmodule
bind general_timer_module gp_timer_monitor mon (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .cpu_halted_in(cpu_halted_in),
  .adc_trigger_out(adc_trigger_out), .irq_out(irq_out));

/* File: tb/rtc_source.sv */
`timescale 1ns/1ps
module rtc_source (
  input  wire  clk_in,
  input  wire  en_in,
  output logic pin_out
);
  // Slow square wave on the capture pin; held low while idle so no stray edge is counted
  logic [1:0] cnt;
  always @(posedge clk_in) begin
    if (!en_in) begin
      cnt <= 2'h0;
      pin_out <= 1'b0;
    end else if (cnt == 2'h2) begin
      cnt <= 2'h0;
      pin_out <= ~pin_out;
    end else begin
      cnt <= cnt + 2'h1;
    end
  end
endmodule

/* File: tb/general_timer_module_bench.sv */
`timescale 1ns/1ps
`include "gp_timer_defines.vh"
module general_timer_module_bench;
  logic clk_in, sys_rst_in, avs_read_in, avs_write_in, cpu_halted_in, pin, rtc_on;
  logic [7:0]  avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, v, w;
  logic        avs_waitrequest_out, adc_trigger_out, irq_out;
  integer n_mismatch, check_count, cyc, n_adc, t_prev, t_last, a0;
  general_timer_module #(.RTC_DIVIDE(4)) dut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(4'hF),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .cpu_halted_in(cpu_halted_in), .capture_compare_pin_in(pin), .adc_trigger_out(adc_trigger_out),
    .irq_out(irq_out));
  rtc_source src (.clk_in(clk_in), .en_in(rtc_on), .pin_out(pin));
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (adc_trigger_out === 1'b1) begin
      n_adc <= n_adc + 1;
      t_prev <= t_last;
      t_last <= cyc;
    end
  end
  task print_verdict;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input [31:0] seen, input [31:0] exp, input string name);
    check_count++;
    if (seen !== exp) begin
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      n_mismatch++;
    end
  endtask
  // Holds the request until waitrequest is sampled low; the slave latency is not assumed
  task wt;
    integer i;
    i = 0;
    @(posedge clk_in);
    while (avs_waitrequest_out !== 1'b0 && i < 50) begin
      i++;
      @(posedge clk_in);
    end
    if (i >= 50) begin
      n_mismatch++;
      print_verdict;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    @(posedge clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= 1'b1;
    wt;
    avs_write_in <= 1'b0;
  endtask
  task rd(input [7:0] a, output [31:0] d);
    @(posedge clk_in);
    avs_address_in <= a;
    avs_read_in <= 1'b1;
    wt;
    d = avs_readdata_out;
    avs_read_in <= 1'b0;
  endtask
  task rc(input [7:0] a, input [31:0] exp, input string name);
    rd(a, v);
    chk(v, exp, name);
  endtask
  task poll(input [31:0] m);
    integer k;
    v = 32'h0;
    for (k = 0; k < 200 && (v & m) == 32'h0; k++) rd(`OFS_RIS, v);
    if ((v & m) == 32'h0) begin
      n_mismatch++;
      print_verdict;
    end
  endtask
  initial begin
    {avs_read_in, avs_write_in, cpu_halted_in, rtc_on} = 4'h0;
    avs_address_in = 8'h00;
    avs_writedata_in = 32'h0;
    {n_mismatch, check_count, cyc, n_adc, t_prev, t_last} = 0;
    sys_rst_in = 1'b1;
    repeat (3) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    rc(`OFS_CFG, 32'h0, "cfg");
    rc(`OFS_CTL, 32'h0, "ctl");
    rc(`OFS_AVAL, 32'hFFFFFFFF, "aval");
    rc(`OFS_ALOAD, 32'hFFFFFFFF, "aload");
    rc(`OFS_APRE, 32'h0, "apre");
    rc(`OFS_BPRE, 32'h0, "bpre");
    rc(8'h10, 32'h0, "unmapped");
    wr(`OFS_ALOAD, 32'h00030002);
    rc(`OFS_AVAL, 32'h00030002, "aval32");
    wr(`OFS_CFG, 32'h4);
    rc(`OFS_BLOAD, 32'h3, "bload16");
    rc(`OFS_AVAL, 32'h2, "aval16");
    // 32-bit one-shot; B mode set to periodic must not matter
    wr(`OFS_CFG, 32'h0);
    wr(`OFS_AMODE, 32'h1);
    wr(`OFS_BMODE, 32'h2);
    wr(`OFS_ALOAD, 32'h5);
    wr(`OFS_IMASK, 32'h1);
    a0 = n_adc;
    wr(`OFS_CTL, 32'h21);
    poll(32'h1);
    rc(`OFS_CTL, 32'h20, "oneshot");
    rc(`OFS_AVAL, 32'h5, "reload");
    rc(`OFS_MIS, 32'h1, "mis");
    chk({31'h0, irq_out}, 32'h1, "irq");
    repeat (20) @(posedge clk_in);
    chk(n_adc - a0, 32'h1, "adc count");
    wr(`OFS_ICLR, 32'h1);
    rc(`OFS_RIS, 32'h0, "ris clear");
    chk({31'h0, irq_out}, 32'h0, "irq clear");
    // Periodic, both freeze bits set so the halt stops it
    wr(`OFS_AMODE, 32'h2);
    wr(`OFS_ALOAD, 32'h9);
    wr(`OFS_CTL, 32'h223);
    repeat (40) @(posedge clk_in);
    chk(t_last - t_prev, 32'd10, "period32");
    cpu_halted_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    rd(`OFS_AVAL, w);
    repeat (5) @(posedge clk_in);
    rc(`OFS_AVAL, w, "stall");
    cpu_halted_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    rd(`OFS_AVAL, v);
    chk({31'h0, v !== w}, 32'h1, "resume");
    wr(`OFS_ALOAD, 32'h1000);
    rd(`OFS_AVAL, v);
    chk({31'h0, v >= 32'hFF0 && v <= 32'h1000}, 32'h1, "load run");
    wr(`OFS_CTL, 32'h0);
    // Two 16-bit timers: A one-shot, B periodic with prescale 2
    wr(`OFS_CFG, 32'h4);
    wr(`OFS_BMODE, 32'h2);
    wr(`OFS_BPRE, 32'h2);
    wr(`OFS_BLOAD, 32'h3);
    wr(`OFS_AMODE, 32'h1);
    wr(`OFS_ALOAD, 32'h1);
    wr(`OFS_ICLR, 32'h109);
    wr(`OFS_IMASK, 32'h101);
    wr(`OFS_CTL, 32'h2101);
    repeat (60) @(posedge clk_in);
    chk(t_last - t_prev, 32'd12, "period16");
    rc(`OFS_RIS, 32'h101, "ris16");
    rc(`OFS_CTL, 32'h2100, "oneshot16");
    wr(`OFS_CTL, 32'h0);
    wr(`OFS_ICLR, 32'h109);
    // Clock mode counts through a debug halt because the clock enable overrides freeze
    wr(`OFS_CFG, 32'h1);
    rc(`OFS_AVAL, 32'h1, "preset");
    wr(`OFS_AMATCH, 32'h3);
    wr(`OFS_IMASK, 32'h8);
    cpu_halted_in <= 1'b1;
    wr(`OFS_CTL, 32'h213);
    rtc_on <= 1'b1;
    poll(32'h8);
    rd(`OFS_AVAL, v);
    chk({31'h0, v <= 32'h1}, 32'h1, "rollover");
    rc(`OFS_MIS, 32'h8, "rtc mis");
    chk({31'h0, irq_out}, 32'h1, "rtc irq");
    wr(`OFS_ICLR, 32'h8);
    rc(`OFS_RIS, 32'h0, "rtc ris");
    rc(`OFS_MIS, 32'h0, "rtc mis clr");
    print_verdict;
  end
endmodule
